// >>> rtl/lp_clock_keep.sv
// Purpose : Debug low-power clock keeping for sleep and stop modes
// Assumes : Core requests are on clk; por_reset is a synchronous power-on reset
// Notes   : debug_control_reg survives system reset; written via plain write strobe
`timescale 1ns/100ps

module lp_clock_keep
    import lp_clock_keep_pkg::*;
(
    // Clock and resets
    input  wire logic                  clk,
    input  wire logic                  reset,        // System reset
    input  wire logic                  por_reset,    // Power-on reset
    // Debug control write port
    input  wire logic                  ctrl_wr,
    input  wire logic [CTRL_WIDTH-1:0] ctrl_wdata,
    output logic      [CTRL_WIDTH-1:0] debug_control_reg,
    // Core low-power requests
    input  wire logic                  sleep_req,
    input  wire logic                  stop_req,
    input  wire logic                  wakeup,
    // Clock gating outputs
    output logic                       core_clk_en,
    output logic                       bus_clk_en,
    output clk_src_e                   clk_source,
    output logic                       in_low_power
);

    // ------------------------------------------------------------
    // Debug control register
    // ------------------------------------------------------------
    // Only power-on reset clears it so a debug session survives system reset
    always_ff @(posedge clk) begin
        if (por_reset) begin
            debug_control_reg <= CTRL_POR_VALUE;
        end else if (ctrl_wr) begin
            debug_control_reg <= ctrl_wdata;
        end
    end

    // ------------------------------------------------------------
    // Sequencer state and held options
    // ------------------------------------------------------------
    lp_state_e state;            // Current low-power mode
    lp_state_e next_state;       // Next mode
    logic      held_sleep_opt;   // Sleep option frozen at entry
    logic      held_stop_opt;    // Stop option frozen at entry
    logic      after_stop;       // Running from RC after stop exit
    logic      next_after_stop;  // Next value of after_stop

    wire enter_sleep = (state == ST_RUN) && sleep_req && !stop_req;
    wire enter_stop  = (state == ST_RUN) && stop_req;
    wire leave_lp    = (state != ST_RUN) && wakeup;

    // Next-state decode; stop wins when both are requested
    always_comb begin
        next_state      = state;
        next_after_stop = after_stop;
        case (state)
            ST_RUN: begin
                if (enter_stop) begin
                    next_state = ST_STOP;
                end else if (enter_sleep) begin
                    next_state = ST_SLEEP;
                end
                // Software reconfigures clocks later; RC stays until reset
            end
            ST_SLEEP: begin
                if (leave_lp) begin
                    next_state = ST_RUN;   // Configuration kept
                end
            end
            ST_STOP: begin
                if (leave_lp) begin
                    next_state      = ST_RUN;
                    next_after_stop = 1'b1;  // Exit on RC oscillator
                end
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    // State register and option capture at entry
    always_ff @(posedge clk) begin
        if (reset) begin
            state          <= ST_RUN;
            held_sleep_opt <= 1'b0;
            held_stop_opt  <= 1'b0;
            after_stop     <= 1'b0;
            in_low_power   <= 1'b0;
        end else begin
            state      <= next_state;
            after_stop <= next_after_stop;
            // Flag is a flop that tracks the state register edge for edge
            in_low_power <= (next_state != ST_RUN);
            if (enter_sleep || enter_stop) begin
                held_sleep_opt <= debug_control_reg[SLEEP_BIT];
                held_stop_opt  <= debug_control_reg[STOP_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Gating decision
    // ------------------------------------------------------------
    lp_gate_if dec_bus ();

    // Sleep: core on always, bus follows option; stop: both follow option
    assign dec_bus.core_clk_on = (state == ST_STOP) ? held_stop_opt : 1'b1;
    assign dec_bus.bus_clk_on  = (state == ST_SLEEP) ? held_sleep_opt :
                                 (state == ST_STOP)  ? held_stop_opt  : 1'b1;
    assign dec_bus.source      = (state == ST_STOP) ? (held_stop_opt ? SRC_RC_OSC : SRC_NONE)
                                                    : SRC_SYSTEM;
    // RC after a stop exit is the configured clock, so sleep keeps it too
    assign dec_bus.force_rc    = after_stop && (state != ST_STOP);

    lp_clock_gate u_gate (
        .clk         (clk),
        .reset       (reset),
        .dec         (dec_bus),
        .core_clk_en (core_clk_en),
        .bus_clk_en  (bus_clk_en),
        .clk_source  (clk_source)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Plain sleep: bus clock stops, core clock keeps running
    property p_sleep_bus_gated;
        @(posedge clk) disable iff (reset)
        (state == ST_SLEEP && !held_sleep_opt) |=> (!bus_clk_en && core_clk_en);
    endproperty
    a_sleep_bus_gated: assert property (p_sleep_bus_gated) else $error("bus clock not gated in sleep");

    // Debug sleep: both clocks stay on the source that ran before entry
    property p_sleep_keep;
        @(posedge clk) disable iff (reset)
        (state == ST_SLEEP && held_sleep_opt) |=> (bus_clk_en && core_clk_en &&
            clk_source == (after_stop ? SRC_RC_OSC : SRC_SYSTEM));
    endproperty
    a_sleep_keep: assert property (p_sleep_keep) else $error("clocks not kept in debug sleep");

    // Debug stop: both clocks kept alive from the RC oscillator
    property p_stop_rc;
        @(posedge clk) disable iff (reset)
        (state == ST_STOP && held_stop_opt) |=> (core_clk_en && bus_clk_en && clk_source == SRC_RC_OSC);
    endproperty
    a_stop_rc: assert property (p_stop_rc) else $error("stop clocks not on RC");

    // Plain stop: every clock is gated off
    property p_stop_off;
        @(posedge clk) disable iff (reset)
        (state == ST_STOP && !held_stop_opt) |=> (!core_clk_en && !bus_clk_en);
    endproperty
    a_stop_off: assert property (p_stop_off) else $error("clocks running in plain stop");

    // Decision reaches the gate flops one cycle after the wake edge
    property p_stop_exit_rc;
        @(posedge clk) disable iff (reset)
        (state == ST_STOP && wakeup) |=> ##1 (clk_source == SRC_RC_OSC);
    endproperty
    a_stop_exit_rc: assert property (p_stop_exit_rc) else $error("stop exit not on RC");

    // Sleep exit must not disturb the configured source
    property p_sleep_exit_sys;
        @(posedge clk) disable iff (reset)
        (state == ST_SLEEP && wakeup && !after_stop) |=> ##1 (clk_source == SRC_SYSTEM);
    endproperty
    a_sleep_exit_sys: assert property (p_sleep_exit_sys) else $error("sleep exit changed config");

    // Option writes while parked only matter at the next entry
    property p_opt_held;
        @(posedge clk) disable iff (reset)
        (state != ST_RUN) |=> $stable(held_sleep_opt) && $stable(held_stop_opt);
    endproperty
    a_opt_held: assert property (p_opt_held) else $error("option changed during low power");

    // Each strobe lands in the register on the following edge
    property p_write;
        @(posedge clk) disable iff (por_reset)
        ctrl_wr |=> (debug_control_reg == $past(ctrl_wdata));
    endproperty
    a_write: assert property (p_write) else $error("control write not stored");

    property p_sysreset_keeps;
        @(posedge clk) disable iff (por_reset)
        (reset && !ctrl_wr) |=> $stable(debug_control_reg);
    endproperty
    a_sysreset_keeps: assert property (p_sysreset_keeps) else $error("system reset altered control");

    // Any system reset parks the enables on and the source on RC
    property p_reset_values;
        @(posedge clk)
        reset |=> (core_clk_en && bus_clk_en && clk_source == SRC_RC_OSC && !in_low_power);
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("outputs not at reset values");

    // After a stop exit the block keeps running on RC until system reset
    property p_after_stop_rc;
        @(posedge clk) disable iff (reset)
        (after_stop && state == ST_RUN) |=> (clk_source == SRC_RC_OSC);
    endproperty
    a_after_stop_rc: assert property (p_after_stop_rc) else $error("run after stop not on RC");

    // A request seen in run state is taken on that very edge
    property p_entry_flag;
        @(posedge clk) disable iff (reset)
        (state == ST_RUN && (sleep_req || stop_req)) |=> in_low_power;
    endproperty
    a_entry_flag: assert property (p_entry_flag) else $error("low-power request not taken");

endmodule : lp_clock_keep

// >>> common/lp_clock_keep_pkg.sv
// Purpose : Shared constants for the debug low-power clock-keeping block
// Assumes : One 125 MHz clock, synchronous active-high reset
// Notes   : No software-visible bus; option bits arrive on plain ports
package lp_clock_keep_pkg;

    // ------------------------------------------------------------
    // Option bit positions inside debug_control_reg
    // ------------------------------------------------------------
    localparam int          CTRL_WIDTH     = 3;
    localparam int          SLEEP_BIT      = 0;
    localparam int          STOP_BIT       = 1;
    localparam int          STANDBY_BIT    = 2;
    localparam logic [2:0]  CTRL_POR_VALUE = 3'h0;

    // ------------------------------------------------------------
    // Clock source selections
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_SYSTEM,      // Previously configured system clock
        SRC_RC_OSC,      // internal_rc_8mhz_osc
        SRC_NONE         // Everything stopped
    } clk_src_e;

    // Low-power mode sequencer states
    typedef enum logic [1:0] {
        ST_RUN,
        ST_SLEEP,
        ST_STOP
    } lp_state_e;

endpackage : lp_clock_keep_pkg

// >>> common/lp_gate_if.sv
// Purpose : Carries the gating decision from sequencer to gate logic
// Assumes : Single clock domain
// Notes   : Decision signals are combinational in the sequencer; the gate registers them
`timescale 1ns/100ps
interface lp_gate_if;
    import lp_clock_keep_pkg::*;
    logic     core_clk_on;   // core_free_clock enable
    logic     bus_clk_on;    // Bus clock enable
    clk_src_e source;        // Selected clock source
    logic     force_rc;      // Run from RC oscillator after stop

    modport seq  (output core_clk_on, output bus_clk_on, output source, output force_rc);
    modport gate (input core_clk_on, input bus_clk_on, input source, input force_rc);
endinterface : lp_gate_if

// >>> rtl/lp_clock_gate.sv
// Purpose : Turns the held gating decision into clock enables and source select
// Assumes : Decision is stable while a low-power mode lasts
// Notes   : Outputs registered so enables change only on clk edges
`timescale 1ns/100ps
module lp_clock_gate
    import lp_clock_keep_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Decision from sequencer
    lp_gate_if.gate   dec,
    // Gate outputs
    output logic      core_clk_en,
    output logic      bus_clk_en,
    output clk_src_e  clk_source
);

    // ------------------------------------------------------------
    // Register the enables
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            core_clk_en <= 1'b1;
            bus_clk_en  <= 1'b1;
            clk_source  <= SRC_RC_OSC;   // Reset state runs from RC oscillator
        end else begin
            core_clk_en <= dec.core_clk_on;
            bus_clk_en  <= dec.bus_clk_on;
            clk_source  <= dec.force_rc ? SRC_RC_OSC : dec.source;
        end
    end

endmodule : lp_clock_gate

// >>> dv/lp_debug_host.sv
// Purpose : Debugger model that writes the debug option bits
// Assumes : Writes start just after a clk edge
// Notes   : Data lines carry junk while the strobe is low
`timescale 1ns/100ps
module lp_debug_host
    import lp_clock_keep_pkg::*;
(
    // Clock
    input  wire logic                  clk,
    // Write port toward the block
    output logic                       ctrl_wr,
    output logic      [CTRL_WIDTH-1:0] ctrl_wdata
);
    initial begin
        ctrl_wr    = 1'b0;
        ctrl_wdata = 3'h0;
    end
    // One-cycle strobe; data held only for the taking edge
    task automatic write(input logic [CTRL_WIDTH-1:0] v);
        @(posedge clk);
        ctrl_wr    <= 1'b1;
        ctrl_wdata <= v;
        @(posedge clk);
        ctrl_wr    <= 1'b0;
        ctrl_wdata <= ~v;  // Released data must not look valid
    endtask : write
    // Clock restart after stop is left to software, outside this model
endmodule : lp_debug_host

// >>> dv/tb_lp_clock_keep.sv
// Purpose : Self-checking bench for the low-power clock keeper
// Assumes : Options reach the block only through the host model
// Notes   : Expected gating comes from a small reference task
`timescale 1ns/100ps
module tb_lp_clock_keep
    import lp_clock_keep_pkg::*;
;
    logic                  clk          = 1'b0;
    logic                  reset        = 1'b1;  // System reset
    logic                  por_reset    = 1'b1;  // Power-on reset
    logic                  sleep_req    = 1'b0;
    logic                  stop_req     = 1'b0;
    logic                  wakeup       = 1'b0;
    logic                  ctrl_wr;
    logic [CTRL_WIDTH-1:0] ctrl_wdata;
    logic [CTRL_WIDTH-1:0] debug_control_reg;
    logic                  core_clk_en;
    logic                  bus_clk_en;
    clk_src_e              clk_source;
    logic                  in_low_power;
    int                    err_total    = 0;
    int                    comparisons  = 0;
    int                    rc_model     = 0;     // Model: running on RC after a stop exit

    always #4 clk = ~clk;

    lp_debug_host host (.clk(clk), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata));
    lp_clock_keep DUT (.clk(clk), .reset(reset), .por_reset(por_reset), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .debug_control_reg(debug_control_reg), .sleep_req(sleep_req),
        .stop_req(stop_req), .wakeup(wakeup), .core_clk_en(core_clk_en), .bus_clk_en(bus_clk_en),
        .clk_source(clk_source), .in_low_power(in_low_power));

    // ------------------------------------------------------------
    // Compare tasks
    // ------------------------------------------------------------
    task automatic fail(input string m);
        err_total++;
        $display("CHECK FAILED t=%0t %s", $time, m);
    endtask : fail
    task automatic chk_reg(input logic [CTRL_WIDTH-1:0] e);
        comparisons++;
        if (debug_control_reg !== e) fail("option register");
    endtask : chk_reg
    task automatic chk_clk(input logic c, input logic b, input clk_src_e s);
        comparisons++;
        if ({core_clk_en, bus_clk_en, clk_source} !== {c, b, s}) fail("clock gating");
    endtask : chk_clk
    // Reference model of the gating held in a low-power mode
    task automatic chk_parked(input int stop, input int opt);
        if (stop != 0) chk_clk(opt[1], opt[1], opt[1] ? SRC_RC_OSC : SRC_NONE);
        else chk_clk(1'b1, opt[0], (rc_model != 0) ? SRC_RC_OSC : SRC_SYSTEM);
    endtask : chk_parked
    // Bounded wait on the low-power flag; a hang ends the run
    task automatic wait_lp(input logic e);
        int n;
        n = 0;
        #1;
        while (in_low_power !== e) begin
            @(posedge clk);
            #1;
            n++;
            if (n > 16) begin
                fail("low-power flag timeout");
                end_of_test();
            end
        end
    endtask : wait_lp

    // ------------------------------------------------------------
    // One entry and exit of a low-power mode
    // ------------------------------------------------------------
    task automatic cycle_mode(input int stop, input int opt);
        host.write(opt[2:0]);
        #1 chk_reg(opt[2:0]);
        // Bit 3 skips the system reset so RC running carries into this mode
        if (opt[3] == 1'b0) begin
            @(posedge clk) reset <= 1'b1;
            @(posedge clk) reset <= 1'b0;
            rc_model = 0;
        end
        repeat (2) @(posedge clk);
        #1 chk_reg(opt[2:0]);
        @(posedge clk);
        stop_req  <= stop[0];
        sleep_req <= ~stop[0] | opt[2];  // Both high tests stop winning
        @(posedge clk);
        stop_req  <= 1'b0;
        sleep_req <= 1'b0;
        wait_lp(1'b1);
        repeat (2) @(posedge clk);
        #1 chk_parked(stop, opt);
        // Option change while parked must wait for the next entry
        host.write(~opt[2:0]);
        repeat (2) @(posedge clk);
        #1 chk_parked(stop, opt);
        chk_reg(~opt[2:0]);
        @(posedge clk) wakeup <= 1'b1;
        @(posedge clk) wakeup <= 1'b0;
        wait_lp(1'b0);
        if (stop != 0) rc_model = 1;
        repeat (2) @(posedge clk);
        #1 chk_clk(1'b1, 1'b1, (rc_model != 0) ? SRC_RC_OSC : SRC_SYSTEM);
    endtask : cycle_mode

    task automatic end_of_test();
        if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------
    // Main sequence: all option pairs in both modes, then random
    // ------------------------------------------------------------
    initial begin
        void'($urandom(74690));
        repeat (20) @(posedge clk);
        reset     <= 1'b0;
        por_reset <= 1'b0;
        @(posedge clk) #1 chk_reg(CTRL_POR_VALUE);
        for (int i = 0; i < 14; i++)
            cycle_mode(i % 2, (i < 8) ? (i / 2) + 4 * ($urandom % 2) : ($urandom % 16) | ((i == 10) ? 8 : 0));
        @(posedge clk) por_reset <= 1'b1;
        @(posedge clk) por_reset <= 1'b0;
        #1 chk_reg(CTRL_POR_VALUE);
        end_of_test();
    end
endmodule : tb_lp_clock_keep
